// ==== rtl/rcds_shifter.v ====
// What this block does
// - rotate-left opcode 027 turns word plus carry as 17-bit ring leftward
// - rotate left: bit 15 goes to carry, old carry to bit 0
// - rotate-right opcode 028 turns word plus carry as 17-bit ring rightward
// - rotate right: bit 0 goes to carry, old carry to bit 15
// - after a rotate, equals flag set exactly when result word is zero
// - after a rotate, carry holds the bit rotated out of the word
// - after a rotate, negative flag copies result bit 15
// - digit left 074 moves every digit one place toward end word top
// - digit left puts zero into start word bits 3 to 0
// - digit left drops end word bits 15 to 12, no flag keeps them
// - digit right 075 moves every digit one place toward start word bottom
// - digit right puts zero into end word bits 15 to 12
// - digit right drops start word bits 3 to 0
// - digit shifts set error when start exceeds end, else clear it
`timescale 1ns/1ps
`include "rcds_map.vh"
module rcds_shifter (
  input wire clock,
  input wire reset,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_WRITE = 2'd2;

  reg [15:0] mem [0:`RCDS_MEM_DEPTH-1];
  reg [1:0] state;
  reg [7:0] opcode;
  reg [7:0] startAddr;
  reg [7:0] endAddr;
  reg [7:0] memAddr;
  reg [7:0] walkAddr;
  reg [15:0] operandWord;
  reg [15:0] resultWord;
  reg [15:0] curWord;
  reg [3:0] carryDigit;
  reg errorFlag;
  reg equalsFlag;
  reg carryFlag;
  reg negativeFlag;
  reg [1:0] irqStatus;
  reg [1:0] irqMask;
  reg [7:0] awAddrHeld;
  reg [31:0] wDataHeld;
  reg awHave;
  reg wHave;
  reg [15:0] rotated;
  reg rotOut;

  wire busy = (state != ST_IDLE);
  wire digitLeft = (opcode == `RCDS_OP_DIGIT_LEFT);
  wire writeGo = awHave && wHave && !s_axi_bvalid;
  wire readGo = s_axi_arvalid && s_axi_arready;
  wire rdIrq = readGo && (s_axi_araddr == `RCDS_IRQ_STATUS_ADDR);
  wire launch = writeGo && (awAddrHeld == `RCDS_CTRL_ADDR) && !busy;
  wire [7:0] newOp = wDataHeld[`RCDS_CTRL_OP_MSB:0];
  wire isRotL = (newOp == `RCDS_OP_ROTATE_LEFT);
  wire isRotR = (newOp == `RCDS_OP_ROTATE_RIGHT);
  wire isDigit = (newOp == `RCDS_OP_DIGIT_LEFT) || (newOp == `RCDS_OP_DIGIT_RIGHT);
  wire lastWord = (walkAddr == (digitLeft ? endAddr : startAddr));

  ////////////////////////////////////////////////////////////////
  // rotate datapath, one cycle
  // other opcodes pass the word through unused
  always @* begin
    rotated = operandWord;
    rotOut = carryFlag;
    if (isRotL) begin
      rotated = {operandWord[14:0], carryFlag};
      rotOut = operandWord[15];
    end else if (isRotR) begin
      rotated = {carryFlag, operandWord[15:1]};
      rotOut = operandWord[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order
  always @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCDS_RESP_OKAY;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h00000000;
    end else begin
      s_axi_awready <= !awHave && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHave && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awAddrHeld <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wDataHeld <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (writeGo) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // launching while a digit walk runs is refused
        s_axi_bresp <= (awAddrHeld == `RCDS_CTRL_ADDR && busy) ? `RCDS_RESP_SLVERR :
          (awAddrHeld > `RCDS_MEM_DATA_ADDR || awAddrHeld[1:0] != 2'b00) ?
          `RCDS_RESP_SLVERR : `RCDS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // axi4-lite read side
  always @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RCDS_RESP_OKAY;
    end else begin
      // ready toggles while idle; a held arvalid meets the next high
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (readGo) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RCDS_RESP_OKAY;
        case (s_axi_araddr)
          `RCDS_CTRL_ADDR: s_axi_rdata <= {24'h000000, opcode};
          `RCDS_START_ADDR: s_axi_rdata <= {24'h000000, startAddr};
          `RCDS_END_ADDR: s_axi_rdata <= {24'h000000, endAddr};
          `RCDS_OPERAND_ADDR: s_axi_rdata <= {16'h0000, operandWord};
          `RCDS_RESULT_ADDR: s_axi_rdata <= {16'h0000, resultWord};
          `RCDS_FLAGS_ADDR: s_axi_rdata <= {27'h0000000, busy, negativeFlag,
            carryFlag, equalsFlag, errorFlag};
          `RCDS_IRQ_STATUS_ADDR: s_axi_rdata <= {30'h00000000, irqStatus};
          `RCDS_IRQ_MASK_ADDR: s_axi_rdata <= {30'h00000000, irqMask};
          `RCDS_MEM_ADDR_ADDR: s_axi_rdata <= {24'h000000, memAddr};
          `RCDS_MEM_DATA_ADDR: s_axi_rdata <= {16'h0000, mem[memAddr]};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RCDS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // operation engine and software-visible registers
  always @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
      opcode <= 8'h00;
      startAddr <= 8'h00;
      endAddr <= 8'h00;
      memAddr <= 8'h00;
      walkAddr <= 8'h00;
      operandWord <= 16'h0000;
      resultWord <= 16'h0000;
      curWord <= 16'h0000;
      carryDigit <= 4'h0;
      errorFlag <= 1'b0;
      equalsFlag <= 1'b0;
      carryFlag <= 1'b0;
      negativeFlag <= 1'b0;
      irqStatus <= 2'b00;
      irqMask <= 2'b00;
    end else begin
      // read clears status; new events below override the clear
      if (rdIrq) begin
        irqStatus <= 2'b00;
      end
      // writes during a walk dropped, chain stays consistent
      if (writeGo && !busy) begin
        case (awAddrHeld)
          `RCDS_START_ADDR: startAddr <= wDataHeld[7:0];
          `RCDS_END_ADDR: endAddr <= wDataHeld[7:0];
          `RCDS_OPERAND_ADDR: operandWord <= wDataHeld[15:0];
          `RCDS_IRQ_MASK_ADDR: irqMask <= wDataHeld[1:0];
          `RCDS_MEM_ADDR_ADDR: memAddr <= wDataHeld[7:0];
          `RCDS_MEM_DATA_ADDR: mem[memAddr] <= wDataHeld[15:0];
          default: begin
          end
        endcase
      end
      if (launch) begin
        opcode <= newOp;
        if (isRotL || isRotR) begin
          resultWord <= rotated;
          operandWord <= rotated;
          carryFlag <= rotOut;
          equalsFlag <= (rotated == 16'h0000);
          negativeFlag <= rotated[15];
          errorFlag <= 1'b0;
          irqStatus[`RCDS_IRQ_DONE] <= 1'b1;
        end else if (newOp == `RCDS_OP_SET_CARRY) begin
          carryFlag <= 1'b1;
          irqStatus[`RCDS_IRQ_DONE] <= 1'b1;
        end else if (newOp == `RCDS_OP_CLEAR_CARRY) begin
          carryFlag <= 1'b0;
          irqStatus[`RCDS_IRQ_DONE] <= 1'b1;
        end else if (isDigit) begin
          if (startAddr > endAddr) begin
            errorFlag <= 1'b1;
            irqStatus <= 2'b11;
          end else begin
            errorFlag <= 1'b0;
            carryDigit <= 4'h0;
            walkAddr <= (newOp == `RCDS_OP_DIGIT_LEFT) ? startAddr : endAddr;
            state <= ST_READ;
          end
        end else begin
          irqStatus[`RCDS_IRQ_ERROR] <= 1'b1;
        end
      end
      case (state)
        ST_IDLE: begin
        end
        ST_READ: begin
          curWord <= mem[walkAddr];
          state <= ST_WRITE;
        end
        ST_WRITE: begin
          // two cycles per word: long chains hold busy for long
          if (digitLeft) begin
            mem[walkAddr] <= {curWord[11:0], carryDigit};
            carryDigit <= curWord[15:12];
          end else begin
            mem[walkAddr] <= {carryDigit, curWord[15:4]};
            carryDigit <= curWord[3:0];
          end
          if (lastWord) begin
            state <= ST_IDLE;
            irqStatus[`RCDS_IRQ_DONE] <= 1'b1;
          end else begin
            walkAddr <= digitLeft ? walkAddr + 8'h01 : walkAddr - 8'h01;
            state <= ST_READ;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // level interrupt, registered
  // one cycle behind status, keeps the pin glitch-free
  always @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end
endmodule

// ==== common/rcds_map.vh ====
`ifndef RCDS_MAP_VH
`define RCDS_MAP_VH
// axi4-lite register byte offsets
`define RCDS_CTRL_ADDR 8'h00
`define RCDS_START_ADDR 8'h04
`define RCDS_END_ADDR 8'h08
`define RCDS_OPERAND_ADDR 8'h0C
`define RCDS_RESULT_ADDR 8'h10
`define RCDS_FLAGS_ADDR 8'h14
`define RCDS_IRQ_STATUS_ADDR 8'h18
`define RCDS_IRQ_MASK_ADDR 8'h1C
`define RCDS_MEM_ADDR_ADDR 8'h20
`define RCDS_MEM_DATA_ADDR 8'h24
// ctrl fields: opcode in bits 7:0, write launches
`define RCDS_CTRL_OP_MSB 7
// opcodes, decimal function codes written in hex
`define RCDS_OP_ROTATE_LEFT 8'h1B
`define RCDS_OP_ROTATE_RIGHT 8'h1C
`define RCDS_OP_SET_CARRY 8'h28
`define RCDS_OP_CLEAR_CARRY 8'h29
`define RCDS_OP_DIGIT_LEFT 8'h4A
`define RCDS_OP_DIGIT_RIGHT 8'h4B
// flags register bit positions
`define RCDS_FLAG_ERROR 0
`define RCDS_FLAG_EQUALS 1
`define RCDS_FLAG_CARRY 2
`define RCDS_FLAG_NEGATIVE 3
`define RCDS_FLAG_BUSY 4
// irq status bits
`define RCDS_IRQ_DONE 0
`define RCDS_IRQ_ERROR 1
// word memory
`define RCDS_MEM_DEPTH 256
`define RCDS_MEM_AW 8
`define RCDS_RESP_OKAY 2'b00
`define RCDS_RESP_SLVERR 2'b10
`endif

// ==== testbench/rcds_shifter_monitor.sv ====
`timescale 1ns/1ps
module rcds_shifter_monitor (
  input wire clock,
  input wire reset,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_artake; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_rans; s_artake |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold; s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read valid stuck");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write valid stuck");
  property p_awtake; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_awtake: assert property (p_awtake) else $error("address ready stuck");
  property p_wtake; s_axi_wvalid && s_axi_wready |=> !s_axi_wready; endproperty
  a_wtake: assert property (p_wtake) else $error("data ready stuck");
  property p_bafter; $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bafter: assert property (p_bafter) else $error("response before both taken");
endmodule
bind rcds_shifter rcds_shifter_monitor u_mon (.*);

// ==== testbench/rcds_seq_model.sv ====
`timescale 1ns/1ps
module rcds_seq_model (
  input wire clock,
  output logic [7:0] s_axi_awaddr = 8'h00,
  output logic s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [7:0] s_axi_araddr = 8'h00,
  output logic s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  logic hung = 1'b0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hung = hung | (n == 100);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    int stall;
    stall = $urandom_range(2);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      // slow consumer on some reads
      if (n == stall) s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hung = hung | (n == 100);
  endtask
endmodule

// ==== testbench/rcds_shifter_tb_top.sv ====
`timescale 1ns/1ps
`include "rcds_map.vh"
module rcds_shifter_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [15:0] mem [0:255];
  logic [15:0] nx [0:255];
  logic [16:0] x = 17'h0;
  logic [15:0] w;
  logic c, lft, bad;
  int errors = 0;
  int comparisons = 0;
  int i, k, s, e;
  always #5 clock = ~clock;
  rcds_shifter DUT (.*);
  rcds_seq_model P (.*);
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    comparisons++;
    if (g !== ex) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    P.wr(a, d, rs);
    if (P.hung) begin errors++; tally_and_finish(); end
  endtask
  task automatic rd(input logic [7:0] a);
    P.rd(a, rv, rs);
    if (P.hung) begin errors++; tally_and_finish(); end
  endtask
  task automatic run(input logic [7:0] op);
    int n;
    wr(`RCDS_CTRL_ADDR, {24'h0, op});
    for (n = 0; n < 200; n++) begin
      rd(`RCDS_FLAGS_ADDR);
      if (rv[`RCDS_FLAG_BUSY] === 1'b0) break;
    end
    if (n == 200) begin errors++; tally_and_finish(); end
  endtask
  function automatic logic [16:0] rot(input logic l, input logic [15:0] v, input logic cy);
    return l ? {v, cy} : {v[0], cy, v[15:1]};
  endfunction
  function automatic logic [15:0] dig(input logic r, input int j, input int a, input int b);
    if (r) return {j == b ? 4'h0 : mem[j+1][3:0], mem[j][15:4]};
    return {mem[j][11:0], j == a ? 4'h0 : mem[j-1][15:12]};
  endfunction
  initial begin
    void'($urandom(32'h7571));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    wr(`RCDS_IRQ_MASK_ADDR, 32'h2);
    chk("bresp", `RCDS_RESP_OKAY, rs);
    // digit chains, one word, longer, last one with start above end
    for (i = 0; i < 8; i++) begin
      s = 1 + $urandom_range(199);
      e = s + ((i < 2) ? 0 : $urandom_range(5));
      bad = (i == 7);
      for (k = s - 1; k <= e + 1; k++) begin
        mem[k] = $urandom;
        wr(`RCDS_MEM_ADDR_ADDR, k);
        wr(`RCDS_MEM_DATA_ADDR, {16'h0, mem[k]});
      end
      for (k = s - 1; k <= e + 1; k++) nx[k] = (bad || k > e || k < s) ? mem[k] : dig(i[0], k, s, e);
      // one memory, so start and end share a data area
      wr(`RCDS_START_ADDR, bad ? e + 1 : s);
      wr(`RCDS_END_ADDR, e);
      run(i[0] ? `RCDS_OP_DIGIT_RIGHT : `RCDS_OP_DIGIT_LEFT);
      rd(`RCDS_FLAGS_ADDR);
      chk("error", bad, rv[`RCDS_FLAG_ERROR]);
      for (k = s - 1; k <= e + 1; k++) begin
        wr(`RCDS_MEM_ADDR_ADDR, k);
        rd(`RCDS_MEM_DATA_ADDR);
        chk("word", {16'h0, nx[k]}, rv);
      end
    end
    chk("irq", 1'b1, irq);
    rd(`RCDS_IRQ_STATUS_ADDR);
    chk("status", 32'h3, rv);
    repeat (2) @(posedge clock);
    chk("irq", 1'b0, irq);
    // rotates; every third one keeps the carry left by the previous rotate
    for (i = 0; i < 24; i++) begin
      w = (i == 1) ? 16'h0 : (i == 2) ? 16'h8000 : (i == 3) ? 16'h0001 : 16'($urandom);
      c = (i % 3 == 0) ? x[16] : 1'($urandom);
      lft = (i < 3) ? i[0] : 1'($urandom);
      wr(`RCDS_OPERAND_ADDR, {16'h0, w});
      if (i % 3 != 0) run(c ? `RCDS_OP_SET_CARRY : `RCDS_OP_CLEAR_CARRY);
      run(lft ? `RCDS_OP_ROTATE_LEFT : `RCDS_OP_ROTATE_RIGHT);
      x = rot(lft, w, c);
      rd(`RCDS_RESULT_ADDR);
      chk("result", {16'h0, x[15:0]}, rv);
      rd(`RCDS_FLAGS_ADDR);
      chk("flags", {28'h0, x[15], x[16], x[15:0] == 16'h0, 1'b0}, rv);
    end
    chk("irq", 1'b0, irq);
    // unknown opcode only raises the error status bit
    run(8'h00);
    chk("irq", 1'b1, irq);
    rd(`RCDS_IRQ_STATUS_ADDR);
    chk("status", 32'h3, rv);
    rd(8'h40);
    chk("rresp", `RCDS_RESP_SLVERR, rs);
    chk("rdata", 32'h0, rv);
    wr(8'h40, 32'h0);
    chk("bresp", `RCDS_RESP_SLVERR, rs);
    tally_and_finish();
  end
endmodule
